// [pkg/psd_pkg.sv]
package psd_pkg;

    // ****************************************
    // Address window and page register
    // ****************************************
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] PAGE_SEL_ADDR = 8'hA7;
    localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_FIFTEEN = 8'h0F;
    localparam logic [3:0] BIT_NIB_A = 4'h0;
    localparam logic [3:0] BIT_NIB_B = 4'h8;

    // ****************************************
    // Decode classes
    // ****************************************
    typedef enum logic [3:0] {
        PSD_NONE   = 4'b0001,
        PSD_COMMON = 4'b0010,
        PSD_PAGED  = 4'b0100,
        PSD_RSVD   = 4'b1000
    } psd_class_t;

    // Access request from the core
    typedef struct packed {
        logic       valid;
        logic       direct;
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psd_req_t;

    // Routed access toward the register blocks
    typedef struct packed {
        logic       sel;
        logic       common;
        logic       rsvd;
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } psd_route_t;

endpackage

// [rtl/psd_decoder.sv]
module psd_decoder (
    input  wire logic                i_clk,     // System clock
    input  wire logic                i_reset_n, // Async reset, low
    input  wire psd_pkg::psd_req_t   i_req,     // Core access
    input  wire logic [7:0]          i_rdata,   // Read data from blocks
    output logic                     o_ram_sel, // Access goes to data RAM
    output psd_pkg::psd_route_t      o_route,   // Routed access
    output logic [7:0]               o_rdata,   // Data back to core
    output logic                     o_bit_err, // Illegal bit access
    output logic [7:0]               o_page     // Current page value
);

    // ****************************************
    // Reset synchroniser
    // ****************************************
    logic rst_m_q;
    logic rst_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_m_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q <= rst_m_q;
        end
    end

    // ****************************************
    // Decode functions
    // ****************************************
    function automatic logic is_common(input logic [7:0] a);
        unique case (a)
            8'hE0, 8'hF0, 8'hD0, 8'h81, 8'h82, 8'h83, 8'h80, 8'h90,
            8'hA0, 8'hA8, 8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hA9, 8'h87,
            8'hA7: is_common = 1'b1;
            default: is_common = 1'b0;
        endcase
    endfunction

    function automatic logic is_page_f(input logic [7:0] a);
        unique case (a)
            8'h91, 8'h92, 8'h93, 8'h95, 8'h96, 8'h97, 8'hA4, 8'hA5,
            8'hA6, 8'hBA, 8'hBD, 8'h85, 8'h86: is_page_f = 1'b1;
            default: is_page_f = 1'b0;
        endcase
    endfunction

    function automatic logic is_page_0_hole(input logic [7:0] a);
        unique case (a)
            8'hE5, 8'hB4: is_page_0_hole = 1'b1;
            default: is_page_0_hole = 1'b0;
        endcase
    endfunction

    function automatic psd_pkg::psd_class_t classify(
        input logic [7:0] page,
        input logic [7:0] a
    );
        if (is_common(a)) begin
            classify = psd_pkg::PSD_COMMON;
        end else if (page == psd_pkg::PAGE_ZERO) begin
            classify = is_page_0_hole(a) ? psd_pkg::PSD_RSVD
                                         : psd_pkg::PSD_PAGED;
        end else if (page == psd_pkg::PAGE_FIFTEEN) begin
            classify = is_page_f(a) ? psd_pkg::PSD_PAGED
                                    : psd_pkg::PSD_RSVD;
        end else begin
            classify = psd_pkg::PSD_RSVD;
        end
    endfunction

    // ****************************************
    // Combinational decode
    // ****************************************
    logic in_window;
    logic bit_ok;
    logic page_wr;
    logic [7:0] page_q;
    psd_pkg::psd_class_t cls;

    assign in_window = i_req.valid && i_req.direct &&
                       (i_req.addr >= psd_pkg::SFR_BASE);
    assign bit_ok = (i_req.addr[3:0] == psd_pkg::BIT_NIB_A) ||
                    (i_req.addr[3:0] == psd_pkg::BIT_NIB_B);
    assign cls = in_window ? classify(page_q, i_req.addr)
                           : psd_pkg::PSD_NONE;
    assign page_wr = in_window && i_req.wr &&
                     (i_req.addr == psd_pkg::PAGE_SEL_ADDR) &&
                     (!i_req.bit_op || bit_ok);

    // ****************************************
    // Page select register
    // ****************************************
    // reset to page zero
    always_ff @(posedge i_clk or negedge rst_q) begin
        if (!rst_q) begin
            page_q <= psd_pkg::PAGE_SEL_RESET;
        end else if (page_wr) begin
            page_q <= i_req.wdata;
        end
    end

    // ****************************************
    // Routed outputs
    // ****************************************
    logic bad_bit;
    assign bad_bit = in_window && i_req.bit_op && !bit_ok;

    always_ff @(posedge i_clk or negedge rst_q) begin
        if (!rst_q) begin
            o_route <= '0;
            o_ram_sel <= 1'b0;
            o_bit_err <= 1'b0;
            o_rdata <= 8'h00;
            o_page <= psd_pkg::PAGE_SEL_RESET;
        end else begin
            o_ram_sel <= i_req.valid && !in_window;
            o_bit_err <= bad_bit;
            o_page <= page_wr ? i_req.wdata : page_q;
            o_route.common <= cls == psd_pkg::PSD_COMMON;
            o_route.rsvd <= cls == psd_pkg::PSD_RSVD;
            o_route.sel <= (cls == psd_pkg::PSD_COMMON ||
                            cls == psd_pkg::PSD_PAGED) && !bad_bit;
            o_route.wr <= i_req.wr;
            o_route.rd <= i_req.rd;
            o_route.bit_op <= i_req.bit_op;
            o_route.page <= page_q;
            o_route.addr <= i_req.addr;
            o_route.wdata <= i_req.wdata;
            if (in_window && i_req.rd &&
                i_req.addr == psd_pkg::PAGE_SEL_ADDR) begin
                o_rdata <= page_q;
            end else if (cls == psd_pkg::PSD_RSVD || bad_bit) begin
                o_rdata <= 8'h00;
            end else begin
                o_rdata <= i_rdata;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence page_write_s;
        page_wr;
    endsequence

    window_route_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (i_req.valid && i_req.direct && i_req.addr[7]) |=> !o_ram_sel)
        else $error("window access went to RAM");

    bit_align_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (in_window && i_req.bit_op && i_req.addr[2:0] != 3'h0)
        |=> (o_bit_err && !o_route.sel))
        else $error("misaligned bit access not flagged");

    reset_page_a: assert property (
        @(posedge i_clk) $rose(rst_q) |-> page_q == 8'h00)
        else $error("page not zero after reset");

    page_load_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        page_write_s |=> page_q == $past(i_req.wdata))
        else $error("page select not loaded");

    page_hold_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        !page_wr |=> $stable(page_q))
        else $error("page changed without write");

    common_any_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (in_window && i_req.addr == 8'hE0) |=> o_route.common)
        else $error("accumulator not common");

    page_f_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (in_window && !i_req.bit_op && page_q == psd_pkg::PAGE_FIFTEEN &&
         i_req.addr == 8'h91)
        |=> (o_route.sel && !o_route.common && o_route.page == 8'h0F))
        else $error("page fifteen register not routed");

    other_page_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (in_window && page_q == 8'h07 && i_req.addr == 8'h91)
        |=> (o_route.rsvd && !o_route.sel))
        else $error("unknown page not reserved");

    page_read_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (in_window && i_req.rd && i_req.addr == 8'hA7)
        |=> o_rdata == $past(page_q))
        else $error("page select readback wrong");

    rsvd_read_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (cls == psd_pkg::PSD_RSVD) |=> (o_rdata == 8'h00 && !o_route.sel))
        else $error("reserved slot not blocked");

    bit_page_a: assert property (
        @(posedge i_clk) disable iff (!rst_q)
        (in_window && i_req.wr && i_req.bit_op &&
         i_req.addr == psd_pkg::PAGE_SEL_ADDR) |=> $stable(page_q))
        else $error("bit write moved page select");

endmodule

// [test/psd_core_model.sv]
module psd_core_model (
    input wire logic i_clk, // System clock
    output psd_pkg::psd_req_t o_req // Request to decoder
);
    timeunit 1ns;
    timeprecision 1ns;
    logic global_irq_enable = 1'b1;
    logic saved_irq_enable;
    initial o_req = '0;
    task automatic acc(input logic w, r, b, d, input logic [7:0] a, wd);
        @(posedge i_clk);
        o_req <= '{1'b1, d, w, r, b, a, wd};
    endtask
    // Gaps leave stale fields scrambled
    task automatic idle();
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'($urandom), 8'($urandom)};
    endtask
    task automatic far_access(input logic [7:0] a);
        saved_irq_enable = global_irq_enable;
        global_irq_enable = 1'b0;
        acc(1, 0, 0, 1, 8'hA8, {global_irq_enable, 7'h00});
        acc(1, 0, 0, 1, 8'hA7, 8'h0F);
        acc(0, 1, 0, 1, a, 8'h00);
        acc(1, 0, 0, 1, 8'hA7, 8'h00);
        global_irq_enable = saved_irq_enable;
        acc(1, 0, 0, 1, 8'hA8, {global_irq_enable, 7'h00});
    endtask
endmodule

// [test/paged_sfr_space_decoder_tb.sv]
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module paged_sfr_space_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0;
    logic i_reset_n = 0;
    logic [7:0] i_rdata = '0;
    psd_pkg::psd_req_t req, e_req;
    psd_pkg::psd_route_t o_route;
    logic o_ram_sel, o_bit_err;
    logic [7:0] o_rdata, o_page, page_m, e_rd, e_pg;
    logic en = 0, e_en = 0, e_v, e_win, e_berr, e_rdv;
    logic [1:0] e_cls;
    int err_total = 0, checks_done = 0;
    psd_decoder dut_u (.i_clk, .i_reset_n, .i_req(req), .i_rdata,
        .o_ram_sel, .o_route, .o_rdata, .o_bit_err, .o_page);
    psd_core_model core_u (.i_clk, .o_req(req));
    // ****************************************
    // Reference decode
    // ****************************************
    function automatic logic [1:0] cls(logic [7:0] p, a);
        if (a inside {8'hE0, 8'hF0, 8'hD0, 8'h81, 8'h82, 8'h83, 8'h80,
            8'h90, 8'hA0, 8'hA8, 8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hA9,
            8'h87, 8'hA7}) return 2'd1;
        if (p == 8'h00 && !(a inside {8'hE5, 8'hB4})) return 2'd2;
        if (p == 8'h0F && a inside {[8'h91:8'h93], [8'h95:8'h97],
            [8'hA4:8'hA6], 8'hBA, 8'hBD, 8'h85, 8'h86}) return 2'd2;
        return 2'd0;
    endfunction
    always @(posedge i_clk) begin
        e_en = en;
        e_v = en && req.valid;
        e_win = req.direct && req.addr >= 8'h80;
        e_berr = e_win && req.bit_op && !(req.addr[3:0] inside {0, 8});
        e_cls = cls(page_m, req.addr);
        e_rdv = req.rd;
        e_req = req;
        e_pg = page_m;
        e_rd = req.addr == 8'hA7 ? page_m : e_cls == 0 ? 8'h00 : i_rdata;
        if (e_v && e_win && !e_berr && req.wr && req.addr == 8'hA7)
            page_m = req.wdata;
        if (!i_reset_n)
            page_m = 8'h00;
        i_rdata <= 8'($urandom);
    end
    always @(negedge i_clk) if (e_en) begin
        `CHK(o_page, page_m)
        `CHK(o_ram_sel, e_v && !e_win)
        `CHK(o_bit_err, e_v && e_berr)
        `CHK(o_route.sel, e_v && e_win && !e_berr && e_cls != 0)
        `CHK(o_route.addr, e_req.addr)
        `CHK(o_route.wdata, e_req.wdata)
        `CHK(o_route.wr, e_req.wr)
        `CHK(o_route.rd, e_req.rd)
        `CHK(o_route.bit_op, e_req.bit_op)
        if (e_v && e_win && !e_berr) begin
            `CHK(o_route.common, e_cls == 1)
            `CHK(o_route.rsvd, e_cls == 0)
            if (e_cls != 0) `CHK(o_route.page, e_pg)
            if (e_rdv) `CHK(o_rdata, e_rd)
        end
    end
    task automatic do_reset();
        en <= 0;
        @(posedge i_clk);
        i_reset_n <= 0;
        @(posedge i_clk);
        i_reset_n <= 1;
        repeat (3) @(posedge i_clk);
        en <= 1;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial forever #10 i_clk = ~i_clk;
    initial begin
        #100_000;
        err_total++;
        summarize();
    end
    initial begin
        logic [31:0] r;
        void'($urandom(32'h08d0_f862));
        do_reset();
        core_u.acc(0, 1, 0, 1, 8'hA7, 8'h00);
        core_u.acc(1, 0, 0, 1, 8'hA7, 8'h0F);
        core_u.acc(0, 1, 0, 1, 8'h91, 8'h00);
        core_u.acc(0, 1, 0, 1, 8'h85, 8'h00);
        core_u.acc(1, 0, 1, 1, 8'hA7, 8'h07);
        core_u.acc(1, 0, 1, 1, 8'hE0, 8'h01);
        core_u.acc(1, 0, 0, 1, 8'hA7, 8'h07);
        core_u.acc(0, 1, 0, 1, 8'h91, 8'h00);
        core_u.acc(0, 1, 1, 1, 8'hD0, 8'h00);
        core_u.acc(1, 0, 0, 1, 8'hA7, 8'h00);
        core_u.acc(0, 1, 0, 1, 8'hE5, 8'h00);
        core_u.acc(0, 1, 0, 0, 8'h90, 8'h00);
        core_u.acc(1, 0, 0, 1, 8'h7F, 8'h00);
        core_u.far_access(8'hBA);
        repeat (800) begin
            r = $urandom;
            if (r[14:12] == 0)
                core_u.idle();
            if (r[2:0] == 0)
                core_u.acc(1, 0, 0, 1, 8'hA7,
                    r[3] ? r[15:8] : {4'h0, {4{r[4]}}});
            else
                core_u.acc(r[5], !r[5], r[7:6] == 0, r[10:8] != 0,
                    {r[11] | r[12], r[22:16]}, r[31:24]);
        end
        core_u.acc(1, 0, 0, 1, 8'hA7, 8'h0F);
        core_u.idle();
        do_reset();
        core_u.acc(0, 1, 0, 1, 8'h91, 8'h00);
        core_u.idle();
        core_u.idle();
        summarize();
    end
endmodule
